/* hw/conv_status_top.sv */
// Converter control register with one-shot and periodic completion flags.
// Assumes an APB master on pclk; one wait state per transfer.
//
// Function
// (R1) Set one-shot done flag, bit 7, when all enabled one-shot channels finish.
// (R2) Writing one to the one-shot done flag clears it.
// (R3) Set periodic done flag, bit 6, when all enabled periodic channels finish.
// (R4) Writing zero to either done flag leaves it unchanged.
// (R5) Each set done flag can raise the interrupt request.
// (R6) Repeated completions just keep the flag set; one clear write suffices.
// (R7) Hardware never clears a done flag itself, not even on a new cycle.
// (R8) Both done flags are zero under system reset.
// (R9) Every cycle scans enabled channels from lowest to highest number.
// (R10) While periodic mode is on, cycles restart at the repeat delay interval.
// (R11) Bits 31 to 8 and bit 5 read zero; writes to them do nothing.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module conv_status_top
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic conv_busy,
  output logic [3:0] conv_channel
);

  scan_if sc ();

  // ==========================================================================
  // Registers
  logic activate_r;
  logic start_single_r;
  logic start_periodic_r;
  logic single_done_r;
  logic periodic_done_r;
  logic single_done_nxt;
  logic periodic_done_nxt;
  logic [15:0] delay_r;
  logic [11:0] single_mask_r;
  logic [11:0] periodic_channel_mask_r;
  logic [7:0] irq_mask_r;
  logic [15:0] rpt_cnt_r;
  logic rpt_pend_r;
  logic engine_busy_r;
  logic start_r;
  logic kind_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic irq_r;
  logic conv_busy_r;
  logic [3:0] conv_channel_r;

  // ==========================================================================
  // Bus decode
  wire access_ph = psel && penable;
  wire bus_wr = access_ph && pwrite && pready_r;
  wire sel_ctrl = (paddr == conv_status_pkg::OFF_CONTROL);
  wire sel_delay = (paddr == conv_status_pkg::OFF_DELAY);
  wire sel_stat = (paddr == conv_status_pkg::OFF_STATUS);
  wire sel_smask = (paddr == conv_status_pkg::OFF_SINGLE_MASK);
  wire sel_pmask = (paddr == conv_status_pkg::OFF_PERIODIC_MASK);
  wire sel_imask = (paddr == conv_status_pkg::OFF_IRQ_MASK);
  wire mapped = sel_ctrl | sel_delay | sel_stat | sel_smask | sel_pmask | sel_imask;
  wire wr_ctrl = bus_wr && sel_ctrl;
  wire wr_delay = bus_wr && sel_delay;
  wire wr_smask = bus_wr && sel_smask;
  wire wr_pmask = bus_wr && sel_pmask;
  wire wr_imask = bus_wr && sel_imask;

  // Write-one-to-clear strobes; a zero written has no effect
  wire clr_single = wr_ctrl && pwdata[conv_status_pkg::BIT_SINGLE_DONE];  // see (R2) see (R4)
  wire clr_periodic = wr_ctrl && pwdata[conv_status_pkg::BIT_PERIODIC_DONE];  // see (R4)

  // ==========================================================================
  // Completion events from the scanner
  wire set_single = sc.done && !sc.done_periodic;  // see (R1)
  wire set_periodic = sc.done && sc.done_periodic;  // see (R3)

  // Set wins over clear so a completion in the clearing cycle is kept
  assign single_done_nxt = set_single | (single_done_r & ~clr_single);  // see (R6) see (R7)
  assign periodic_done_nxt = set_periodic | (periodic_done_r & ~clr_periodic);  // see (R6)

  // ==========================================================================
  // Read mux, only the documented fields reach the bus
  wire [31:0] ctrl_rd = {24'h000000, single_done_r, periodic_done_r, 3'b000,
                         start_periodic_r, start_single_r, activate_r};  // see (R11)
  wire [31:0] stat_rd = {22'h000000, kind_r, conv_busy_r, 4'h0, conv_channel_r};
  wire [31:0] rd_mux = sel_ctrl ? ctrl_rd :
                       sel_delay ? {16'h0000, delay_r} :
                       sel_stat ? stat_rd :
                       sel_smask ? {20'h00000, single_mask_r} :
                       sel_pmask ? {20'h00000, periodic_channel_mask_r} :
                       sel_imask ? {24'h000000, irq_mask_r} : 32'h00000000;

  // ==========================================================================
  // Cycle launch; one-shot goes first when both are waiting
  wire want_single = start_single_r;
  wire want_periodic = rpt_pend_r;
  wire launch = activate_r && !engine_busy_r && (want_single || want_periodic);
  wire launch_periodic = !want_single;
  wire rpt_run = start_periodic_r && activate_r;
  wire rpt_expire = rpt_run && (rpt_cnt_r == 16'h0000);

  assign sc.start = start_r;
  assign sc.kind_periodic = kind_r;
  assign sc.mask = kind_r ? periodic_channel_mask_r : single_mask_r;

  // ==========================================================================
  // APB answer, one wait state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end
    else
    begin
      pready_r <= access_ph && !pready_r;
      pslverr_r <= access_ph && !pready_r && !mapped;
      prdata_r <= (access_ph && !pready_r && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // ==========================================================================
  // Completion flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      single_done_r <= 1'b0;  // see (R8)
      periodic_done_r <= 1'b0;  // see (R8)
    end
    else
    begin
      single_done_r <= single_done_nxt;
      periodic_done_r <= periodic_done_nxt;
    end
  end

  // ==========================================================================
  // Control and configuration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      activate_r <= 1'b0;
      start_periodic_r <= 1'b0;
      delay_r <= conv_status_pkg::DELAY_RST;
      single_mask_r <= conv_status_pkg::MASK_RST;
      periodic_channel_mask_r <= conv_status_pkg::MASK_RST;
      irq_mask_r <= conv_status_pkg::IRQ_MASK_RST;
    end
    else
    begin
      if (wr_ctrl)
      begin
        activate_r <= pwdata[conv_status_pkg::BIT_ACTIVATE];
        start_periodic_r <= pwdata[conv_status_pkg::BIT_START_PERIODIC];
      end
      if (wr_delay)
        delay_r <= pwdata[15:0];
      if (wr_smask)
        single_mask_r <= pwdata[11:0];
      if (wr_pmask)
        periodic_channel_mask_r <= pwdata[11:0];
      if (wr_imask)
        irq_mask_r <= pwdata[7:0];
    end
  end

  // ==========================================================================
  // One-shot request bit, self-clearing when its cycle is launched
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      start_single_r <= 1'b0;
    else if (wr_ctrl && pwdata[conv_status_pkg::BIT_START_SINGLE])
      start_single_r <= 1'b1;
    else if (launch && !launch_periodic)
      start_single_r <= 1'b0;
  end

  // ==========================================================================
  // Repeat timer; turning periodic mode off reloads it from delay_r and clears any pending cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rpt_cnt_r <= conv_status_pkg::DELAY_RST;
      rpt_pend_r <= 1'b0;
    end
    else if (!rpt_run)
    begin
      rpt_cnt_r <= delay_r;
      rpt_pend_r <= 1'b0;
    end
    else
    begin
      rpt_cnt_r <= rpt_expire ? delay_r : rpt_cnt_r - 16'h0001;  // see (R10)
      if (rpt_expire)
        rpt_pend_r <= 1'b1;  // see (R10)
      else if (launch && launch_periodic)
        rpt_pend_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Engine handshake: busy from launch until the scanner reports done
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      start_r <= 1'b0;
      kind_r <= 1'b0;
      engine_busy_r <= 1'b0;
    end
    else
    begin
      start_r <= launch;
      if (launch)
        kind_r <= launch_periodic;
      if (launch)
        engine_busy_r <= 1'b1;
      else if (sc.done)
        engine_busy_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Interrupt and observation outputs, registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_r <= 1'b0;
      conv_busy_r <= 1'b0;
      conv_channel_r <= 4'h0;
    end
    else
    begin
      // Level output, changes at the same edge as the flags
      irq_r <= |({single_done_nxt, periodic_done_nxt} & irq_mask_r[7:6]);  // see (R5)
      conv_busy_r <= engine_busy_r;
      conv_channel_r <= sc.chan;
    end
  end

  chan_scanner i_chan_scanner
  (
    .pclk(pclk),
    .presetn(presetn),
    .bus(sc.scan)
  );

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
  assign conv_busy = conv_busy_r;
  assign conv_channel = conv_channel_r;

endmodule

/* hw/conv_status_pkg.sv */
// Shared constants for the converter completion status block.
// Assumes a single pclk domain at 50 MHz and an APB slave with 32-bit data.
package conv_status_pkg;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_DELAY = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_SINGLE_MASK = 8'h0C;
  localparam logic [7:0] OFF_PERIODIC_MASK = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h40;

  // ==========================================================================
  // Field positions of the control register
  localparam int BIT_ACTIVATE = 0;
  localparam int BIT_START_SINGLE = 1;
  localparam int BIT_START_PERIODIC = 2;
  localparam int BIT_PERIODIC_DONE = 6;
  localparam int BIT_SINGLE_DONE = 7;

  // Field layout of the status register
  localparam int BIT_STAT_BUSY = 8;
  localparam int BIT_STAT_KIND = 9;

  // ==========================================================================
  // Sizes and reset values
  localparam int NUM_CHAN = 12;
  localparam int CHAN_W = 4;
  localparam int DELAY_W = 16;
  localparam logic [NUM_CHAN-1:0] MASK_RST = 12'h000;
  localparam logic [DELAY_W-1:0] DELAY_RST = 16'h0000;
  localparam logic [7:0] IRQ_MASK_RST = 8'h00;

  // ==========================================================================
  // Timing: one channel conversion
  localparam int CONV_TIME_NS = 500;
  localparam int CLK_PERIOD_NS = 20;
  localparam int CONV_CYCLES_I = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] CONV_CYCLES = 8'(CONV_CYCLES_I);

endpackage

/* hw/scan_if.sv */
// Carries one conversion cycle request and its completion between control and scanner.
// Assumes both ends run on the same pclk.
`timescale 1ns/1ps
interface scan_if;
  logic start;
  logic kind_periodic;
  logic [11:0] mask;
  logic busy;
  logic [3:0] chan;
  logic done;
  logic done_periodic;

  modport ctrl
  (
    output start,
    output kind_periodic,
    output mask,
    input busy,
    input chan,
    input done,
    input done_periodic
  );

  modport scan
  (
    input start,
    input kind_periodic,
    input mask,
    output busy,
    output chan,
    output done,
    output done_periodic
  );
endinterface

/* hw/chan_scanner.sv */
// Walks the enabled channels of one conversion cycle, lowest to highest.
// Assumes start is a one-cycle pulse given only while the scanner is idle.
`timescale 1ns/1ps
module chan_scanner
(
  input wire logic pclk,
  input wire logic presetn,
  scan_if.scan bus
);

  typedef enum logic [1:0]
  {
    S_IDLE = 2'b01,
    S_CONV = 2'b10
  } scan_state_e;

  scan_state_e state_r;
  logic [11:0] mask_r;
  logic [3:0] chan_r;
  logic [7:0] cnt_r;
  logic kind_r;
  logic done_r;
  logic [11:0] cand;
  logic [11:0] lowest;
  logic [3:0] acc [0:12];
  logic any_cand;
  logic [3:0] next_chan;
  logic conv_end;

  // ==========================================================================
  // Next enabled channel above the current one
  assign acc[0] = 4'h0;
  genvar i;
  generate
    for (i = 0; i < conv_status_pkg::NUM_CHAN; i++)
    begin : g_chan
      assign cand[i] = (state_r == S_IDLE) ? bus.mask[i] : (mask_r[i] && (4'(i) > chan_r));
      assign acc[i+1] = acc[i] | (lowest[i] ? 4'(i) : 4'h0);
    end
  endgenerate
  assign lowest = cand & (~cand + 12'h001);  // see (R9)
  assign any_cand = |cand;
  assign next_chan = acc[12];
  assign conv_end = (state_r == S_CONV) && (cnt_r == 8'h00);

  // ==========================================================================
  // Sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= S_IDLE;
      mask_r <= 12'h000;
      chan_r <= 4'h0;
      cnt_r <= 8'h00;
      kind_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= 1'b0;
      unique case (state_r)
        S_IDLE:
        begin
          if (bus.start)
          begin
            mask_r <= bus.mask;
            kind_r <= bus.kind_periodic;
            chan_r <= next_chan;
            cnt_r <= conv_status_pkg::CONV_CYCLES - 8'h01;
            // Empty mask still completes, so the flag is set at once
            if (any_cand)
              state_r <= S_CONV;
            else
              done_r <= 1'b1;
          end
        end
        S_CONV:
        begin
          if (conv_end && any_cand)
          begin
            chan_r <= next_chan;  // see (R9)
            cnt_r <= conv_status_pkg::CONV_CYCLES - 8'h01;
          end
          else if (conv_end)
          begin
            state_r <= S_IDLE;
            done_r <= 1'b1;
          end
          else
            cnt_r <= cnt_r - 8'h01;
        end
      endcase
    end
  end

  assign bus.busy = state_r[1];
  assign bus.chan = chan_r;
  assign bus.done = done_r;
  assign bus.done_periodic = kind_r;

endmodule

/* verif/conv_status_assertions.sv */
// Port-level checks for the converter completion status block.
// Assumes it is bound into conv_status_top, one pclk domain.
`timescale 1ns/1ps
module conv_status_assertions
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic conv_busy,
  input wire logic [3:0] conv_channel
);
  // ==========================================================================
  // Decodes
  wire mapped;
  wire clr_wr;
  assign mapped = paddr inside {conv_status_pkg::OFF_CONTROL, conv_status_pkg::OFF_DELAY,
    conv_status_pkg::OFF_STATUS, conv_status_pkg::OFF_SINGLE_MASK,
    conv_status_pkg::OFF_PERIODIC_MASK, conv_status_pkg::OFF_IRQ_MASK};
  assign clr_wr = pready && pwrite && ((paddr == conv_status_pkg::OFF_CONTROL
    && pwdata[7:6] != 2'h0) || paddr == conv_status_pkg::OFF_IRQ_MASK);

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not after one wait state");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_idle_quiet: assert property (!psel |=> !pready)
    else $error("pready without a transfer");
  a_rsvd_zero: assert property (pready && !pwrite && paddr == 8'h00 |->
    prdata[31:8] == 24'h000000 && prdata[5:3] == 3'h0)
    else $error("reserved control bits read nonzero");
  a_unmapped_err: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_reset_clear: assert property ($rose(presetn) |-> !irq && !pready)
    else $error("outputs not clear after reset");
  // Flag and irq drop at the same edge as the clearing write
  a_irq_no_selfclr: assert property ($fell(irq) |-> $past(clr_wr))
    else $error("interrupt dropped without a clearing write");
  // Channel output lags busy by one cycle, so skip the first busy cycle pair
  a_chan_order: assert property (conv_busy && $past(conv_busy) && $past(conv_busy, 2) |->
    conv_channel >= $past(conv_channel))
    else $error("channel order went backwards");

  c_irq_up: cover property ($rose(irq));
  c_irq_down: cover property ($fell(irq));
  c_refused: cover property (pready && pslverr);
endmodule

bind conv_status_top conv_status_assertions i_conv_status_assertions (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
  .conv_busy(conv_busy), .conv_channel(conv_channel));

/* verif/apb_fw_model.sv */
// Firmware side of the register bus: an APB master with one transfer task.
// Assumes a single pclk; tasks are called from the testbench.
`timescale 1ns/1ps
module apb_fw_model
(
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ==========================================================================
  // Transfer
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench watchdog ends a hung wait
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines flip so stale values never look valid
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

/* verif/adc_done_status_flags_tb.sv */
// Self-checking bench for the converter completion flags.
// Assumes apb_fw_model as bus master and the bound checker.
`timescale 1ns/1ps
module adc_done_status_flags_tb;
  logic pclk;
  logic presetn;
  logic psel, penable, pwrite, pready, pslverr, irq, conv_busy;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] conv_channel;
  int failures = 0;
  int compares = 0;

  conv_status_top i_conv_status_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .conv_busy(conv_busy),
    .conv_channel(conv_channel));
  apb_fw_model i_apb_fw_model (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  // ==========================================================================
  // Clock, tasks
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    i_apb_fw_model.xfer(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
    logic [31:0] q;
    logic e;
    i_apb_fw_model.xfer(1'b0, a, 32'h0, q, e);
    chk(q, exp);
    chk({31'h0, e}, {31'h0, err});
  endtask

  // Bounded wait on irq or busy reaching a level
  task automatic wait_on(input logic use_irq, input logic lvl, input int n);
    int i;
    i = 0;
    while ((use_irq ? irq : conv_busy) !== lvl && i < n)
    begin
      @(posedge pclk);
      i++;
    end
    chk({31'h0, i < n}, 32'h1);
  endtask

  task automatic tally_and_finish;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge pclk);
    failures++;
    tally_and_finish();
  end

  // ==========================================================================
  // Scenarios
  initial
  begin
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(conv_status_pkg::OFF_CONTROL, 32'h0, 1'b0);
    rd(8'h20, 32'h0, 1'b1);
    wr(conv_status_pkg::OFF_CONTROL, 32'hFFFFFF20);
    rd(conv_status_pkg::OFF_CONTROL, 32'h0, 1'b0);
    wr(conv_status_pkg::OFF_SINGLE_MASK, 32'h00000005);
    wr(conv_status_pkg::OFF_IRQ_MASK, 32'h000000C0);
    wr(conv_status_pkg::OFF_CONTROL, 32'h00000003);
    wait_on(1'b1, 1'b1, 200);
    rd(conv_status_pkg::OFF_CONTROL, 32'h00000081, 1'b0);
    rd(conv_status_pkg::OFF_STATUS, 32'h00000002, 1'b0);
    wr(conv_status_pkg::OFF_CONTROL, 32'h00000001);
    rd(conv_status_pkg::OFF_CONTROL, 32'h00000081, 1'b0);
    // Second completion while still set
    wr(conv_status_pkg::OFF_CONTROL, 32'h00000003);
    wait_on(1'b0, 1'b1, 20);
    wait_on(1'b0, 1'b0, 200);
    rd(conv_status_pkg::OFF_CONTROL, 32'h00000081, 1'b0);
    wr(conv_status_pkg::OFF_CONTROL, 32'h00000081);
    rd(conv_status_pkg::OFF_CONTROL, 32'h00000001, 1'b0);
    chk({31'h0, irq}, 32'h0);
    // Masked source keeps irq low
    wr(conv_status_pkg::OFF_IRQ_MASK, 32'h00000040);
    wr(conv_status_pkg::OFF_CONTROL, 32'h00000003);
    wait_on(1'b0, 1'b1, 20);
    wait_on(1'b0, 1'b0, 200);
    rd(conv_status_pkg::OFF_CONTROL, 32'h00000081, 1'b0);
    chk({31'h0, irq}, 32'h0);
    // Reset in mid-run with a flag set
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(conv_status_pkg::OFF_CONTROL, 32'h0, 1'b0);
    // Periodic cycles, delay 300, 301-cycle interval
    wr(conv_status_pkg::OFF_PERIODIC_MASK, 32'h0000000A);
    wr(conv_status_pkg::OFF_DELAY, 32'h0000012C);
    wr(conv_status_pkg::OFF_IRQ_MASK, 32'h000000C0);
    wr(conv_status_pkg::OFF_CONTROL, 32'h00000005);
    wait_on(1'b1, 1'b1, 1000);
    rd(conv_status_pkg::OFF_CONTROL, 32'h00000045, 1'b0);
    wr(conv_status_pkg::OFF_CONTROL, 32'h00000045);
    wait_on(1'b1, 1'b0, 10);
    wait_on(1'b1, 1'b1, 1000);
    rd(conv_status_pkg::OFF_CONTROL, 32'h00000045, 1'b0);
    tally_and_finish();
  end
endmodule
